//--- logic/salu_pkg.sv
package salu_pkg;

    localparam int OPC_W  = 7;
    localparam int DATA_W = 64;

    // fixed two-bit prefix of the two-source scalar format
    localparam logic [1:0] FORMAT_PREFIX = 2'h2;
    localparam int PREFIX_HI = 31;
    localparam int OPC_LO    = 23;
    localparam int DST_LO    = 16;
    localparam int SRC1_LO   = 8;
    localparam int SRC0_LO   = 0;

    // field positions inside the second source for 64-bit extracts
    localparam int WIDE_OFS_HI = 5;
    localparam int WIDE_WID_LO = 16;
    localparam int WIDE_WID_HI = 22;

    localparam logic [OPC_W-1:0] OP_ADD_U    = 7'h00;
    localparam logic [OPC_W-1:0] OP_SUB_U    = 7'h01;
    localparam logic [OPC_W-1:0] OP_ADD_I    = 7'h02;
    localparam logic [OPC_W-1:0] OP_SUB_I    = 7'h03;
    localparam logic [OPC_W-1:0] OP_ADDC     = 7'h04;
    localparam logic [OPC_W-1:0] OP_SUBB     = 7'h05;
    localparam logic [OPC_W-1:0] OP_MIN_I    = 7'h06;
    localparam logic [OPC_W-1:0] OP_MIN_U    = 7'h07;
    localparam logic [OPC_W-1:0] OP_MAX_I    = 7'h08;
    localparam logic [OPC_W-1:0] OP_MAX_U    = 7'h09;
    localparam logic [OPC_W-1:0] OP_CSEL32   = 7'h0A;
    localparam logic [OPC_W-1:0] OP_CSEL64   = 7'h0B;
    localparam logic [OPC_W-1:0] OP_AND32    = 7'h0C;
    localparam logic [OPC_W-1:0] OP_AND64    = 7'h0D;
    localparam logic [OPC_W-1:0] OP_OR32     = 7'h0E;
    localparam logic [OPC_W-1:0] OP_OR64     = 7'h0F;
    localparam logic [OPC_W-1:0] OP_XOR32    = 7'h10;
    localparam logic [OPC_W-1:0] OP_XOR64    = 7'h11;
    localparam logic [OPC_W-1:0] OP_ANDN32   = 7'h12;
    localparam logic [OPC_W-1:0] OP_ANDN64   = 7'h13;
    localparam logic [OPC_W-1:0] OP_ORN32    = 7'h14;
    localparam logic [OPC_W-1:0] OP_ORN64    = 7'h15;
    localparam logic [OPC_W-1:0] OP_NAND32   = 7'h16;
    localparam logic [OPC_W-1:0] OP_NAND64   = 7'h17;
    localparam logic [OPC_W-1:0] OP_NOR32    = 7'h18;
    localparam logic [OPC_W-1:0] OP_NOR64    = 7'h19;
    localparam logic [OPC_W-1:0] OP_XNOR32   = 7'h1A;
    localparam logic [OPC_W-1:0] OP_XNOR64   = 7'h1B;
    localparam logic [OPC_W-1:0] OP_SHL32    = 7'h1C;
    localparam logic [OPC_W-1:0] OP_SHL64    = 7'h1D;
    localparam logic [OPC_W-1:0] OP_SHR32    = 7'h1E;
    localparam logic [OPC_W-1:0] OP_SHR64    = 7'h1F;
    localparam logic [OPC_W-1:0] OP_ASHR32   = 7'h20;
    localparam logic [OPC_W-1:0] OP_ASHR64   = 7'h21;
    localparam logic [OPC_W-1:0] OP_BFM32    = 7'h22;
    localparam logic [OPC_W-1:0] OP_BFM64    = 7'h23;
    localparam logic [OPC_W-1:0] OP_MUL_I    = 7'h24;
    localparam logic [OPC_W-1:0] OP_BFE_U32  = 7'h25;
    localparam logic [OPC_W-1:0] OP_BFE_I32  = 7'h26;
    localparam logic [OPC_W-1:0] OP_BFE_U64  = 7'h27;
    localparam logic [OPC_W-1:0] OP_BFE_I64  = 7'h28;
    localparam logic [OPC_W-1:0] OP_FORK     = 7'h29;
    localparam logic [OPC_W-1:0] OP_ABSDIFF  = 7'h2A;

    localparam logic [DATA_W-1:0] DEST_RESET = 64'h0000_0000_0000_0000;
    localparam logic              FLAG_RESET = 1'b0;

    typedef struct packed {
        logic [OPC_W-1:0]  opcode;
        logic [DATA_W-1:0] src0;
        logic [DATA_W-1:0] src1;
    } alu_req_t;

    typedef struct packed {
        logic [DATA_W-1:0] dest;
        logic              dest_we;
        logic              scalar_condition_flag;
    } alu_res_t;

    typedef struct packed {
        logic [DATA_W-1:0] compare_mask;
        logic [DATA_W-1:0] target_addr;
    } fork_req_t;

endpackage

//--- logic/field_extract.sv
`timescale 1ns/1ps
// bitfield extract, 32-bit three-case form or 64-bit shift-and-mask form
module field_extract (
    // operands
    input  wire logic [63:0] data_i,
    input  wire logic [63:0] ctrl_i,
    // mode
    input  wire logic        wide_i,
    input  wire logic        signed_i,
    // result
    output logic      [63:0] field_o
);
    wire logic [4:0]  ofs5    = ctrl_i[4:0];
    wire logic [4:0]  wid5    = ctrl_i[20:16];
    wire logic [5:0]  ofs6    = ctrl_i[salu_pkg::WIDE_OFS_HI:0];
    wire logic [6:0]  wid7    =
        ctrl_i[salu_pkg::WIDE_WID_HI:salu_pkg::WIDE_WID_LO];
    wire logic [5:0]  span    = {1'b0, ofs5} + {1'b0, wid5};
    wire logic [5:0]  lshamt  = 6'h20 - span;
    wire logic [5:0]  rshamt  = 6'h20 - {1'b0, wid5};
    wire logic [31:0] up      = data_i[31:0] << lshamt;
    wire logic [31:0] nar_s   = $unsigned($signed(up) >>> rshamt);
    wire logic [31:0] nar_u   = up >> rshamt;
    wire logic [31:0] tail_s  = $unsigned($signed(data_i[31:0]) >>> ofs5);
    wire logic [31:0] tail_u  = data_i[31:0] >> ofs5;
    wire logic [31:0] narrow  =
        (wid5 == 5'h0) ? 32'h0000_0000 :
        (span < 6'h20) ? (signed_i ? nar_s : nar_u) :
                         (signed_i ? tail_s : tail_u);
    wire logic [63:0] sh64    = data_i >> ofs6;
    wire logic [63:0] mask64  = (wid7 >= 7'h40) ? {64{1'b1}} :
        ((64'h0000_0000_0000_0001 << wid7) - 64'h0000_0000_0000_0001);
    wire logic [63:0] fld64   = sh64 & mask64;
    wire logic [6:0]  sgnpos  = wid7 - 7'h1;
    wire logic        sgnbit  = fld64[sgnpos[5:0]];
    wire logic [63:0] sext64  =
        (signed_i && wid7 != 7'h0 && wid7 < 7'h40 && sgnbit) ?
        (fld64 | ~mask64) : fld64;
    assign field_o = wide_i ? sext64 :
        {{32{signed_i & narrow[31]}}, narrow};
endmodule

//--- logic/scalar_two_operand_alu.sv
`timescale 1ns/1ps
//
// Contract
// - abs difference, flag if non-zero
// - unsigned add, flag is carry out
// - signed add, flag is signed overflow
// - add with flag carry-in, flag carry out
// - signed subtract, flag is borrow
// - subtract with borrow, flag borrow out
// - logic ops flag non-zero result
// - arithmetic right shift by five bits
// - 64-bit left shift by six bits
// - logical right shift by five bits
// - signed 32-bit field extract, three cases
// - unsigned 32-bit field extract, zero-extended
// - 64-bit unsigned shift then width mask
// - 64-bit signed extract, sign-extended flag test
// - mask of width src0, shifted by src1
// - select src0 if flag, keep flag
// - 64-bit flag select, keep flag
// - unsigned max, flag if first chosen
// - signed min, flag if first chosen
// - fork request with mask and target
//
module scalar_two_operand_alu #(
    parameter int DATA_W = 64
) (
    // clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    arst_n_i,
    // instruction from the sequencer
    input  wire logic                    issue_valid_i,
    input  wire logic [31:0]             instr_word_i,
    input  wire logic [DATA_W-1:0]       src0_i,
    input  wire logic [DATA_W-1:0]       src1_i,
    // result to the scalar register file
    output logic                         result_valid_o,
    output logic [DATA_W-1:0]            dest_o,
    output logic [7:0]                   dest_select_o,
    output logic                         scalar_condition_flag_o,
    // branch-stack fork request
    output logic                         fork_valid_o,
    output logic [DATA_W-1:0]            fork_mask_o,
    output logic [DATA_W-1:0]            fork_target_o,
    // decode status
    output logic                         illegal_op_o
);
    logic [1:0] rst_sync;
    wire  logic rst_n = rst_sync[1];

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end

    logic flag;

    // format and field decode
    wire logic [1:0] prefix =
        instr_word_i[salu_pkg::PREFIX_HI -: 2];
    wire logic [6:0] opc =
        instr_word_i[salu_pkg::OPC_LO +: salu_pkg::OPC_W];
    wire logic [7:0] dsel = instr_word_i[salu_pkg::DST_LO +: 8];
    wire logic is_fmt = issue_valid_i &&
        (prefix == salu_pkg::FORMAT_PREFIX);

    wire logic [31:0] a = src0_i[31:0];
    wire logic [31:0] b = src1_i[31:0];

    // adders
    wire logic [32:0] sum_u  = {1'b0, a} + {1'b0, b};
    wire logic [32:0] sum_c  = {1'b0, a} + {1'b0, b} + {32'h0, flag};
    wire logic [32:0] dif_u  = {1'b0, a} - {1'b0, b};
    wire logic [32:0] dif_b  = {1'b0, a} - {1'b0, b} - {32'h0, flag};
    wire logic        add_ov = (a[31] == b[31]) &&
        (sum_u[31] != a[31]);
    wire logic        sub_lt = $signed(a) < $signed(b);
    wire logic [31:0] absd   = sub_lt ? (b - a) : dif_u[31:0];

    // compares
    wire logic u_gt  = a > b;
    wire logic u_lt  = a < b;
    wire logic s_gt  = $signed(a) > $signed(b);
    wire logic s_lt  = sub_lt;

    // shifts
    wire logic [31:0] shl32  = a << b[4:0];
    wire logic [63:0] shl64  = src0_i << src1_i[5:0];
    wire logic [31:0] shr32  = a >> b[4:0];
    wire logic [63:0] shr64  = src0_i >> src1_i[5:0];
    wire logic [31:0] ashr32 = $unsigned($signed(a) >>> b[4:0]);
    wire logic [63:0] ashr64 = $unsigned($signed(src0_i) >>> src1_i[5:0]);

    // bitfield masks
    wire logic [31:0] bfm32 =
        ((32'h0000_0001 << a[4:0]) - 32'h0000_0001) << b[4:0];
    wire logic [63:0] bfm64 =
        ((64'h0000_0000_0000_0001 << src0_i[5:0]) -
         64'h0000_0000_0000_0001) << src1_i[5:0];

    wire logic [63:0] mul64 = $signed(a) * $signed(b);

    // extract unit
    wire logic ext_wide = (opc == salu_pkg::OP_BFE_U64) ||
                          (opc == salu_pkg::OP_BFE_I64);
    wire logic ext_sgn  = (opc == salu_pkg::OP_BFE_I32) ||
                          (opc == salu_pkg::OP_BFE_I64);
    logic [63:0] ext_res;

    field_extract u_extract (
        .data_i   (src0_i),
        .ctrl_i   (src1_i),
        .wide_i   (ext_wide),
        .signed_i (ext_sgn),
        .field_o  (ext_res)
    );

    function automatic logic [63:0] z32(input logic [31:0] v);
        z32 = {32'h0000_0000, v};
    endfunction

    logic [63:0] res;
    logic        res_flag;
    logic        flag_we;
    logic        dest_we;
    logic        known;
    logic        is_fork;

    always_comb begin
        res      = 64'h0000_0000_0000_0000;
        res_flag = 1'b0;
        flag_we  = 1'b1;
        dest_we  = 1'b1;
        known    = 1'b1;
        is_fork  = 1'b0;
        unique case (opc)
            salu_pkg::OP_ADD_U: begin
                res = z32(sum_u[31:0]);
                res_flag = sum_u[32];
            end
            salu_pkg::OP_SUB_U: begin
                res = z32(dif_u[31:0]);
                res_flag = dif_u[32];
            end
            salu_pkg::OP_ADD_I: begin
                res = z32(sum_u[31:0]);
                res_flag = add_ov;
            end
            salu_pkg::OP_SUB_I: begin
                res = z32(dif_u[31:0]);
                res_flag = dif_u[32];
            end
            salu_pkg::OP_ADDC: begin
                res = z32(sum_c[31:0]);
                res_flag = sum_c[32];
            end
            salu_pkg::OP_SUBB: begin
                res = z32(dif_b[31:0]);
                res_flag = dif_b[32];
            end
            salu_pkg::OP_MIN_I: begin
                res = z32(s_lt ? a : b);
                res_flag = s_lt;
            end
            salu_pkg::OP_MIN_U: begin
                res = z32(u_lt ? a : b);
                res_flag = u_lt;
            end
            salu_pkg::OP_MAX_I: begin
                res = z32(s_gt ? a : b);
                res_flag = s_gt;
            end
            salu_pkg::OP_MAX_U: begin
                res = z32(u_gt ? a : b);
                res_flag = u_gt;
            end
            salu_pkg::OP_CSEL32: begin
                res = z32(flag ? a : b);
                flag_we = 1'b0;
            end
            salu_pkg::OP_CSEL64: begin
                res = flag ? src0_i : src1_i;
                flag_we = 1'b0;
            end
            salu_pkg::OP_AND32: res = z32(a & b);
            salu_pkg::OP_AND64: res = src0_i & src1_i;
            salu_pkg::OP_OR32: res = z32(a | b);
            salu_pkg::OP_OR64: res = src0_i | src1_i;
            salu_pkg::OP_XOR32: res = z32(a ^ b);
            salu_pkg::OP_XOR64: res = src0_i ^ src1_i;
            salu_pkg::OP_ANDN32: res = z32(a & ~b);
            salu_pkg::OP_ANDN64: res = src0_i & ~src1_i;
            salu_pkg::OP_ORN32: res = z32(a | ~b);
            salu_pkg::OP_ORN64: res = src0_i | ~src1_i;
            salu_pkg::OP_NAND32: res = z32(~(a & b));
            salu_pkg::OP_NAND64: res = ~(src0_i & src1_i);
            salu_pkg::OP_NOR32: res = z32(~(a | b));
            salu_pkg::OP_NOR64: res = ~(src0_i | src1_i);
            salu_pkg::OP_XNOR32: res = z32(~(a ^ b));
            salu_pkg::OP_XNOR64: res = ~(src0_i ^ src1_i);
            salu_pkg::OP_SHL32: res = z32(shl32);
            salu_pkg::OP_SHL64: res = shl64;
            salu_pkg::OP_SHR32: res = z32(shr32);
            salu_pkg::OP_SHR64: res = shr64;
            salu_pkg::OP_ASHR32: res = z32(ashr32);
            salu_pkg::OP_ASHR64: res = ashr64;
            salu_pkg::OP_BFM32: begin
                res = z32(bfm32);
                flag_we = 1'b0;
            end
            salu_pkg::OP_BFM64: begin
                res = bfm64;
                flag_we = 1'b0;
            end
            salu_pkg::OP_MUL_I: begin
                res = z32(mul64[31:0]);
                flag_we = 1'b0;
            end
            salu_pkg::OP_BFE_U32: res = z32(ext_res[31:0]);
            salu_pkg::OP_BFE_I32: res = ext_res;
            salu_pkg::OP_BFE_U64: res = ext_res;
            salu_pkg::OP_BFE_I64: res = ext_res;
            salu_pkg::OP_FORK: begin
                is_fork = 1'b1;
                dest_we = 1'b0;
                flag_we = 1'b0;
            end
            salu_pkg::OP_ABSDIFF: res = z32(absd);
            default: begin
                known = 1'b0;
                dest_we = 1'b0;
                flag_we = 1'b0;
            end
        endcase
    end

    // every op without an explicit flag source, except the selects, bitfield masks, multiply and fork that keep the flag, flags a non-zero result
    wire logic flag_is_nz = (opc >= salu_pkg::OP_AND32) &&
                            (opc != salu_pkg::OP_CSEL32) &&
                            (opc != salu_pkg::OP_CSEL64);
    wire logic next_flag_val = flag_is_nz ? (res != 64'h0) : res_flag;
    wire logic next_flag = (is_fmt && flag_we) ? next_flag_val : flag;

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            flag <= salu_pkg::FLAG_RESET;
        end else begin
            flag <= next_flag;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            result_valid_o <= 1'b0;
            dest_o         <= salu_pkg::DEST_RESET;
            dest_select_o  <= 8'h00;
            fork_valid_o   <= 1'b0;
            fork_mask_o    <= salu_pkg::DEST_RESET;
            fork_target_o  <= salu_pkg::DEST_RESET;
            illegal_op_o   <= 1'b0;
        end else begin
            result_valid_o <= is_fmt && dest_we;
            illegal_op_o   <= is_fmt && !known;
            fork_valid_o   <= is_fmt && is_fork;
            if (is_fmt && dest_we) begin
                dest_o        <= res;
                dest_select_o <= dsel;
            end
            if (is_fmt && is_fork) begin
                fork_mask_o   <= src0_i;
                fork_target_o <= src1_i;
            end
        end
    end

    assign scalar_condition_flag_o = flag;

endmodule

//--- test/regfile_model.sv
`timescale 1ns/1ps
// scalar register file: takes each result write, reads through a bypass
module regfile_model (
    // clock
    input  wire logic        clk_i,
    // write from the unit
    input  wire logic        we_i,
    input  wire logic [7:0]  sel_i,
    input  wire logic [63:0] data_i,
    // read back
    input  wire logic [7:0]  rd_sel_i,
    output logic      [63:0] rd_data_o
);
    logic [63:0] regs [256];
    wire  logic  bypass = we_i && sel_i == rd_sel_i;
    always_ff @(posedge clk_i) begin
        if (we_i) regs[sel_i] <= data_i;
    end
    assign rd_data_o = bypass ? data_i : regs[rd_sel_i];
endmodule

//--- test/alu_checker_asserts.sv
`timescale 1ns/1ps
module alu_checker #(
    parameter int DATA_W = 64
) (
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              arst_n_i,
    // request side
    input  wire logic              issue_valid_i,
    input  wire logic [31:0]       instr_word_i,
    input  wire logic [DATA_W-1:0] src0_i,
    input  wire logic [DATA_W-1:0] src1_i,
    // result side
    input  wire logic              result_valid_o,
    input  wire logic [DATA_W-1:0] dest_o,
    input  wire logic              scalar_condition_flag_o,
    input  wire logic              fork_valid_o,
    input  wire logic [DATA_W-1:0] fork_mask_o,
    input  wire logic [DATA_W-1:0] fork_target_o,
    input  wire logic              illegal_op_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    wire logic [6:0] op   = instr_word_i[29:23];
    wire logic       take = issue_valid_i && instr_word_i[31:30] == 2'b10;

    chk_add_carry: assert property (take && op == 7'h00 |=>
        {scalar_condition_flag_o, dest_o[31:0]} ==
        {1'b0, $past(src0_i[31:0])} + $past(src1_i[31:0]))
        else $error("add carry wrong");
    chk_signed_ovf: assert property (take && op == 7'h02 |=>
        scalar_condition_flag_o == ($past(src0_i[31]) == $past(src1_i[31])
        && dest_o[31] != $past(src0_i[31]))) else $error("overflow wrong");
    chk_or_flag: assert property (take && op == 7'h0E |=>
        dest_o[31:0] == ($past(src0_i[31:0]) | $past(src1_i[31:0]))
        && scalar_condition_flag_o == (dest_o != 0)) else $error("or wrong");
    chk_wide_shift: assert property (take && op == 7'h1D |=>
        dest_o == $past(src0_i) << $past(src1_i[5:0]))
        else $error("wide shift wrong");
    chk_select_narrow: assert property (take && op == 7'h0A |=>
        dest_o[31:0] == ($past(scalar_condition_flag_o) ?
        $past(src0_i[31:0]) : $past(src1_i[31:0]))
        && $stable(scalar_condition_flag_o)) else $error("select wrong");
    chk_select_wide: assert property (take && op == 7'h0B |=>
        dest_o == ($past(scalar_condition_flag_o) ? $past(src0_i)
        : $past(src1_i)) && $stable(scalar_condition_flag_o))
        else $error("wide select wrong");
    chk_fork_req: assert property (take && op == 7'h29 |=> fork_valid_o
        && fork_mask_o == $past(src0_i) && fork_target_o == $past(src1_i))
        else $error("fork request wrong");
    chk_unknown_op: assert property (take && op > 7'h2A |=> illegal_op_o
        && !result_valid_o && $stable(scalar_condition_flag_o)
        && $stable(dest_o)) else $error("unknown opcode had effect");
    chk_prefix_gate: assert property (issue_valid_i
        && instr_word_i[31:30] != 2'b10 |=> !result_valid_o
        && !fork_valid_o && !illegal_op_o) else $error("bad prefix taken");
endmodule

bind scalar_two_operand_alu alu_checker #(.DATA_W(DATA_W)) u_alu_checker (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .issue_valid_i(issue_valid_i),
    .instr_word_i(instr_word_i), .src0_i(src0_i), .src1_i(src1_i),
    .result_valid_o(result_valid_o), .dest_o(dest_o),
    .scalar_condition_flag_o(scalar_condition_flag_o),
    .fork_valid_o(fork_valid_o), .fork_mask_o(fork_mask_o),
    .fork_target_o(fork_target_o), .illegal_op_o(illegal_op_o));

//--- test/tb_scalar_two_operand_alu.sv
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_scalar_two_operand_alu;
    logic        clk_i;
    logic        arst_n_i;
    logic        issue_valid_i;
    logic [31:0] instr_word_i;
    logic [63:0] src0_i;
    logic [63:0] src1_i;
    logic        result_valid_o;
    logic [63:0] dest_o;
    logic [7:0]  dest_select_o;
    logic        scalar_condition_flag_o;
    logic        fork_valid_o;
    logic [63:0] fork_mask_o;
    logic [63:0] fork_target_o;
    logic        illegal_op_o;
    logic [63:0] rd_data;
    logic [63:0] mdest;
    logic [63:0] ra;
    logic [63:0] rb;
    logic        mflag;
    logic [6:0]  ops[$];
    int          fails;
    int          num_checks;
    int          cyc;
    int          seed;

    scalar_two_operand_alu #(.DATA_W(64)) u_scalar_two_operand_alu (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .issue_valid_i(issue_valid_i),
        .instr_word_i(instr_word_i), .src0_i(src0_i), .src1_i(src1_i),
        .result_valid_o(result_valid_o), .dest_o(dest_o),
        .dest_select_o(dest_select_o),
        .scalar_condition_flag_o(scalar_condition_flag_o),
        .fork_valid_o(fork_valid_o), .fork_mask_o(fork_mask_o),
        .fork_target_o(fork_target_o), .illegal_op_o(illegal_op_o));
    regfile_model u_regfile_model (
        .clk_i(clk_i), .we_i(result_valid_o), .sel_i(dest_select_o),
        .data_i(dest_o), .rd_sel_i(dest_select_o), .rd_data_o(rd_data));

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 2000) begin
            fails++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // returns {flag, dest}; flag passes through for flag-keeping opcodes
    function automatic logic [64:0] model(input logic [6:0] op,
        input logic [63:0] a, input logic [63:0] b, input logic f);
        logic [32:0] s;
        logic [63:0] d;
        logic [63:0] m;
        logic [4:0]  o;
        logic [4:0]  w;
        logic [6:0]  ww;
        longint      x;
        logic        nf;
        o  = b[4:0];
        w  = b[20:16];
        ww = b[22:16];
        d  = 64'h0;
        nf = f;
        case (op) inside
            7'h00, 7'h04: begin
                s  = {1'b0, a[31:0]} + b[31:0] + (op == 7'h04 && f);
                d  = s[31:0];
                nf = s[32];
            end
            7'h01, 7'h03, 7'h05: begin
                s  = {1'b0, a[31:0]} - b[31:0] - (op == 7'h05 && f);
                d  = s[31:0];
                nf = s[32];
            end
            7'h02: begin
                d  = 32'(a[31:0] + b[31:0]);
                nf = a[31] == b[31] && d[31] != a[31];
            end
            7'h06: begin
                nf = $signed(a[31:0]) < $signed(b[31:0]);
                d  = nf ? a[31:0] : b[31:0];
            end
            7'h09: begin
                nf = a[31:0] > b[31:0];
                d  = nf ? a[31:0] : b[31:0];
            end
            7'h07: begin
                nf = a[31:0] < b[31:0];
                d  = nf ? a[31:0] : b[31:0];
            end
            7'h08: begin
                nf = $signed(a[31:0]) > $signed(b[31:0]);
                d  = nf ? a[31:0] : b[31:0];
            end
            7'h0A: d = f ? a[31:0] : b[31:0];
            7'h0B: d = f ? a : b;
            [7'h0C:7'h1B]: begin
                case (op[4:1])
                    4'h6: d = a & b;
                    4'h7: d = a | b;
                    4'h8: d = a ^ b;
                    4'h9: d = a & ~b;
                    4'hA: d = a | ~b;
                    4'hB: d = ~(a & b);
                    4'hC: d = ~(a | b);
                    default: d = ~(a ^ b);
                endcase
                if (!op[0]) d = {32'h0000_0000, d[31:0]};
            end
            7'h1C: d = 32'(a[31:0] << o);
            7'h1D: d = a << b[5:0];
            7'h1E: d = a[31:0] >> o;
            7'h1F: d = a >> b[5:0];
            7'h20: d = {32'h0000_0000, 32'($signed(a[31:0]) >>> o)};
            7'h21: d = $signed(a) >>> b[5:0];
            7'h23: d = ((64'h1 << a[5:0]) - 1) << b[5:0];
            7'h24: d = {32'h0000_0000,
                        32'($signed(a[31:0]) * $signed(b[31:0]))};
            7'h22: d = 32'((64'h1 << a[4:0]) - 1 << o);
            7'h25, 7'h26: begin
                m = (64'h1 << w) - 1;
                if (w == 5'h0) d = 64'h0;
                else if (o + w < 32) begin
                    d = (a[31:0] >> o) & m;
                    if (op == 7'h26 && d[w - 1]) d = d | ~m;
                end else if (op == 7'h26) d = 64'($signed(a[31:0]) >>> o);
                else d = a[31:0] >> o;
            end
            7'h27, 7'h28: begin
                m = ww >= 7'd64 ? '1 : (64'h1 << ww) - 1;
                d = (a >> b[5:0]) & m;
                if (op == 7'h28 && ww != 0 && ww < 64 && d[ww - 1])
                    d = d | ~m;
            end
            7'h2A: begin
                x = longint'($signed(a[31:0])) - longint'($signed(b[31:0]));
                d = {32'h0000_0000, 32'(x < 0 ? -x : x)};
            end
            default: d = 64'h0;
        endcase
        if (op inside {[7'h0C:7'h21], [7'h25:7'h28], 7'h2A})
            nf = d != 0;
        return {nf, d};
    endfunction

    // drives one instruction at a falling edge, checks one cycle later
    task automatic go(input logic [6:0] op, input logic [63:0] a,
                      input logic [63:0] b, input logic [1:0] pre = 2'b10);
        logic [64:0] e;
        logic [22:0] low;
        low           = 23'($random(seed));
        e             = model(op, a, b, mflag);
        issue_valid_i = 1'b1;
        instr_word_i  = {pre, op, low};
        src0_i        = a;
        src1_i        = b;
        @(negedge clk_i);
        if (pre != 2'b10) begin
            `CHK({result_valid_o, fork_valid_o, illegal_op_o}, 3'b000)
        end else if (op == 7'h29) begin
            `CHK({fork_valid_o, fork_mask_o, fork_target_o}, {1'b1, a, b})
        end else if (op > 7'h2A) begin
            `CHK({illegal_op_o, result_valid_o, dest_o}, {2'b10, mdest})
        end else begin
            mdest = e[63:0];
            mflag = e[64];
            `CHK({result_valid_o, dest_select_o}, {1'b1, op[0], low[22:16]})
            `CHK(dest_o, mdest)
            `CHK(rd_data, mdest)
        end
        `CHK(scalar_condition_flag_o, mflag)
    endtask

    initial begin
        arst_n_i      = 1'b0;
        issue_valid_i = 1'b0;
        instr_word_i  = 32'h0000_0000;
        src0_i        = 64'h0;
        src1_i        = 64'h0;
        seed          = 32'h1481;
        mflag         = 1'b0;
        mdest         = 64'h0;
        repeat (2) @(negedge clk_i);
        `CHK({result_valid_o, dest_o, scalar_condition_flag_o}, 66'h0)
        arst_n_i = 1'b1;
        repeat (2) @(negedge clk_i);
        go(7'h00, 64'hFFFF_FFFF, 64'h1);
        go(7'h04, 64'h0, 64'hFFFF_FFFF);
        go(7'h02, 64'h7FFF_FFFF, 64'h1);
        go(7'h03, 64'h0, 64'h1);
        go(7'h05, 64'h5, 64'h5);
        go(7'h0A, 64'h1234_5678_AAAA_AAAA, 64'h5);
        go(7'h0B, 64'h1234_5678_AAAA_AAAA, 64'h5);
        go(7'h2A, 64'h8000_0000, 64'h7FFF_FFFF);
        go(7'h26, 64'hF0, 64'h0004_0004);
        go(7'h26, 64'h8000_0000, 64'h0010_001C);
        go(7'h25, 64'hFFFF_FFFF, 64'h0000_0007);
        go(7'h27, 64'hF000_0000_0000_0000, 64'h0040_0001);
        go(7'h28, 64'h0000_0000_0000_00F0, 64'h0004_0004);
        go(7'h22, 64'h0000_0028, 64'h0000_0023);
        go(7'h20, 64'h8000_0000, 64'h0000_003F);
        go(7'h1D, 64'h1, 64'h0000_007F);
        go(7'h1E, 64'h8000_0000, 64'h0000_0020);
        go(7'h09, 64'h5, 64'h5);
        go(7'h06, 64'hFFFF_FFFF, 64'h1);
        go(7'h0E, 64'h0, 64'h0);
        go(7'h2B, 64'h1, 64'h1);
        go(7'h7F, 64'h1, 64'h1);
        go(7'h29, 64'hFFFF_0000_1234_5678, 64'h0000_1000_0000_0040);
        go(7'h00, 64'h1, 64'h1, 2'b01);
        issue_valid_i = 1'b0;
        $display("test directed done");
        @(negedge clk_i);
        for (int k = 0; k <= 'h2A; k++) ops.push_back(7'(k));
        repeat (20) foreach (ops[i]) begin
            ra = {$random(seed), $random(seed)};
            rb = {$random(seed), $random(seed)};
            if (ops[i] inside {7'h25, 7'h26}) rb = rb & 64'h001F_001F;
            go(ops[i], ra, rb);
        end
        issue_valid_i = 1'b0;
        $display("test random done");
        stop_test();
    end
endmodule
